// ---- design/osm_pkg.sv ----
/*
 * Package for the oscillator select and fail-safe monitor block: register
 * offsets, field positions, reset values, source codes and timing counts.
 * Assumes a 250 MHz system clock and a 32-bit Avalon-MM register slave.
 */
// Functional notes
// [R1] fail-safe monitor watches the system clock whenever not sleeping; the code does not count while the current source is fast RC
// [R2] on clock stop: force fast RC source and raise non-maskable interrupt
// [R3] sleep halts both system clock and monitor; no detection while asleep
// [R4] fast RC divider bits 26:24 divide by 1,2,4,8,16,32,64,256; reset 1; the code resets the field to 0 (divide by 1)
// [R5] bit 23 enables dream mode; resets to zero
// [R6] sleep two-speed bit 21: run fast RC until selected clock is ready
// [R7] read-only current oscillator field at bits 14:12 reports active source
// [R8] switch request resets to the two-speed start-up fuse value
// [R9] control writes only take effect after the unlock sequence
// [R10] bits 31:27, 22, 20:15 and 11 read zero and ignore writes
// [R11] peripheral bus clock one can never be switched off
// [R12] external clock or fast RC mode: clock pin carries bus clock one / 2
// [R13] flash fetches on system or bus clock five, programming on fast RC
// [R14] switch request bit 0 starts switch to new source; clears when done
// [R15] clock fail flag bit 3 set by hardware, cleared by software
// [R16] clock lock bit 7 blocks changes to clock selections
// [R17] sleep enable bit 4: wait enters sleep, otherwise idle
// [R18] current field updates in the same cycle switch request clears
package osm_pkg;
    localparam logic [3:0]  OSM_OFF_CTRL     = 4'h0;
    localparam logic [3:0]  OSM_OFF_UNLOCK   = 4'h4;
    localparam logic [3:0]  OSM_OFF_STATUS   = 4'h8;
    localparam logic [3:0]  OSM_OFF_MASK     = 4'hc;
    localparam logic [31:0] OSM_KEY_ONE      = 32'hAA99_6655;
    localparam logic [31:0] OSM_KEY_TWO      = 32'h5566_99AA;
    localparam int OSM_POS_DIV     = 24;
    localparam int OSM_POS_DREAM   = 23;
    localparam int OSM_POS_SLEEP_TWO_SPEED_STARTUP = 21;
    localparam int OSM_POS_CURRENT_OSCILLATOR    = 12;
    localparam int OSM_POS_NEW_OSCILLATOR    = 8;
    localparam int OSM_POS_LOCK    = 7;
    localparam int OSM_POS_SLEEP_ENABLE   = 4;
    localparam int OSM_POS_FAIL    = 3;
    localparam int OSM_POS_SWREQ   = 0;
    localparam logic [31:0] OSM_CTRL_WMASK = 32'h07A0_079F;
    localparam logic [2:0]  OSM_DIV_RESET  = 3'h0;
    localparam logic [2:0]  OSM_SRC_FRC    = 3'h0;
    localparam logic [2:0]  OSM_SRC_SYSTEM_PLL   = 3'h1;
    localparam logic [2:0]  OSM_SRC_PRIMARY_OSCILLATOR   = 3'h2;
    localparam logic [2:0]  OSM_SRC_USB_PLL   = 3'h3;
    localparam logic [2:0]  OSM_SRC_SOSC   = 3'h4;
    localparam logic [2:0]  OSM_SRC_LOW_POWER_RC   = 3'h5;
    localparam int OSM_EVT_FAIL   = 0;
    localparam int OSM_EVT_SWDONE = 1;
    localparam int OSM_NEVT       = 2;
    localparam int OSM_FAIL_NS    = 1000;
    localparam int OSM_CLK_MHZ    = 250;
    localparam int OSM_FAIL_CYC   = OSM_FAIL_NS * OSM_CLK_MHZ / 1000;
    localparam int OSM_UNLOCK_WIN = 8;
    typedef enum logic [1:0] {
        OSM_SW_IDLE = 2'b00,
        OSM_SW_WAIT = 2'b01,
        OSM_SW_DONE = 2'b11
    } osm_sw_e;
    function automatic logic [2:0] osm_field3(input logic [31:0] w,
                                              input int pos);
        osm_field3 = w[pos +: 3];
    endfunction
endpackage

// ---- design/osm_div_if.sv ----
/*
 * Interface from the control core to the clock enable generator.
 * Assumes a single system clock domain.
 */
`timescale 1ns/1ps
interface osm_div_if;
    logic [2:0] div_sel;
    logic       run;
    logic       frc_en;
    logic       pb1_half;
    modport ctrl (output div_sel, output run, input frc_en, input pb1_half);
    modport gen  (input div_sel, input run, output frc_en, output pb1_half);
endinterface

// ---- design/osm_clkgen.sv ----
/*
 * Clock enable generator: divided fast RC enable pulse and the half-rate
 * bus clock one toggle for the clock output pin.
 * Assumes the fast RC oscillator runs at the system clock rate.
 */
`timescale 1ns/1ps
module osm_clkgen
    import osm_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    osm_div_if.gen    d
);
    logic [7:0] cnt_reg, cnt_next;
    logic       half_reg, half_next;
    logic [7:0] limit;

    always_comb begin
        // code 111 is divide by 256, not 128
        limit = (d.div_sel == 3'h7) ? 8'hFF : 8'(({7'h0, 1'b1} << d.div_sel) - 8'h1); // [R4]
        cnt_next  = (cnt_reg >= limit) ? 8'h00 : cnt_reg + 8'h01;
        half_next = ~half_reg; // [R11]
        if (!d.run) begin
            cnt_next = cnt_reg; // [R3]
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg  <= 8'h00;
            half_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            half_reg <= half_next;
        end
    end

    assign d.frc_en   = d.run && (cnt_reg >= limit);
    assign d.pb1_half = half_reg; // [R12]
endmodule

// ---- design/osm_top.sv ----
/*
 * Oscillator select and fail-safe monitor: control register with unlock,
 * clock switch sequencer, clock activity watchdog, interrupt status.
 * Assumes source activity and ready flags synchronous to i_clk_sys.
 */
`timescale 1ns/1ps
module osm_top
    import osm_pkg::*;
#(
    parameter int FAIL_CYC = OSM_FAIL_CYC
)(
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_two_speed_startup_fuse,
    input  wire logic [2:0]  i_fuse_new_oscillator,
    input  wire logic        i_system_clock_tick,
    input  wire logic [5:0]  i_source_ready,
    input  wire logic        i_wait_instr,
    input  wire logic        i_wake,
    input  wire logic        i_flash_program,
    output logic [2:0]       o_system_clock_source,
    output logic             o_failsafe_nmi,
    output logic             o_irq,
    output logic             o_sleeping,
    output logic             o_idle,
    output logic             o_dream_mode_enable,
    output logic             o_internal_fast_rc_en,
    output logic             o_clock_output_pin,
    output logic             o_flash_use_fast_rc
);
    osm_div_if d();
    osm_clkgen u_gen (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .d         (d)
    );

    logic [31:0] ctrl_reg, ctrl_next;
    logic [1:0]  ustate_reg, ustate_next;
    logic [3:0]  uwin_reg, uwin_next;
    logic        strap_reg, strap_next;
    osm_sw_e     sw_reg, sw_next;
    logic [15:0] wd_reg, wd_next;
    logic        sleep_reg, sleep_next;
    logic        idle_reg, idle_next;
    logic        twospd_reg, twospd_next;
    logic [OSM_NEVT-1:0] stat_reg, stat_next, mask_reg, mask_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        ack_reg, ack_next;
    logic        wreq_reg, wreq_next;
    logic [2:0]  src_reg, src_next;
    logic        nmi_reg, nmi_next;
    logic        irq_reg, irq_next;
    logic        clock_output_pin_reg, clock_output_pin_next;
    logic        flash_reg, flash_next;
    logic        frcen_reg;

    logic        req, wr_ok, fail_evt, done_evt;
    logic [2:0]  current_oscillator, new_oscillator;
    logic [31:0] wmask, be_mask;

    assign req  = (i_avs_read || i_avs_write) && !ack_reg;
    assign current_oscillator = osm_field3(ctrl_reg, OSM_POS_CURRENT_OSCILLATOR);
    assign new_oscillator = osm_field3(ctrl_reg, OSM_POS_NEW_OSCILLATOR);
    assign be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                      {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    assign wr_ok = req && i_avs_write && (i_avs_address == OSM_OFF_CTRL)
                   && (ustate_reg == 2'd2); // [R9]

    // unlock: two keys in a row, then a bounded window for one write
    always_comb begin
        ustate_next = ustate_reg;
        uwin_next   = uwin_reg;
        if (ustate_reg == 2'd2) begin
            uwin_next = uwin_reg - 4'h1;
            if (uwin_reg == 4'h0 || wr_ok) begin
                ustate_next = 2'd0;
            end
        end
        if (req && i_avs_write && i_avs_address == OSM_OFF_UNLOCK) begin
            if (i_avs_writedata == OSM_KEY_ONE) begin
                ustate_next = 2'd1;
            end else if (i_avs_writedata == OSM_KEY_TWO
                         && ustate_reg == 2'd1) begin
                ustate_next = 2'd2;
                uwin_next   = 4'(OSM_UNLOCK_WIN);
            end else begin
                ustate_next = 2'd0;
            end
        end
    end

    // clock watchdog, reloaded by each tick of the running clock
    always_comb begin
        wd_next  = wd_reg;
        fail_evt = 1'b0;
        if (sleep_reg) begin
            wd_next = 16'h0000; // [R3]
        end else if (i_system_clock_tick) begin
            wd_next = 16'h0000; // [R1]
        end else if (current_oscillator != OSM_SRC_FRC) begin
            if (wd_reg == 16'(FAIL_CYC - 1)) begin
                fail_evt = 1'b1; // [R1]
                wd_next  = 16'h0000;
            end else begin
                wd_next = wd_reg + 16'h0001;
            end
        end
    end

    // sleep / idle on wait
    always_comb begin
        sleep_next  = sleep_reg;
        idle_next   = idle_reg;
        twospd_next = twospd_reg;
        if (i_wake) begin
            sleep_next  = 1'b0;
            idle_next   = 1'b0;
            twospd_next = sleep_reg && ctrl_reg[OSM_POS_SLEEP_TWO_SPEED_STARTUP]; // [R6]
        end else if (i_wait_instr) begin
            sleep_next = ctrl_reg[OSM_POS_SLEEP_ENABLE]; // [R17]
            idle_next  = !ctrl_reg[OSM_POS_SLEEP_ENABLE]; // [R17]
        end
        if (twospd_reg && i_source_ready[current_oscillator]) begin
            twospd_next = 1'b0; // [R6]
        end
    end

    // control register and switch sequencer
    always_comb begin
        ctrl_next = ctrl_reg;
        sw_next   = sw_reg;
        done_evt  = 1'b0;
        strap_next = 1'b0;
        wmask = OSM_CTRL_WMASK & be_mask; // [R10]
        if (ctrl_reg[OSM_POS_LOCK]) begin
            wmask[OSM_POS_NEW_OSCILLATOR +: 3] = 3'h0; // [R16]
            wmask[OSM_POS_SWREQ]     = 1'b0; // [R16]
            wmask[OSM_POS_LOCK]      = 1'b0;
        end
        if (wr_ok) begin
            ctrl_next = (ctrl_reg & ~wmask) | (i_avs_writedata & wmask);
        end
        if (strap_reg) begin
            ctrl_next[OSM_POS_SWREQ] = i_two_speed_startup_fuse; // [R8]
            ctrl_next[OSM_POS_NEW_OSCILLATOR +: 3] = i_fuse_new_oscillator;
        end
        unique case (sw_reg)
            OSM_SW_IDLE: if (ctrl_reg[OSM_POS_SWREQ]) begin
                sw_next = OSM_SW_WAIT; // [R14]
            end
            OSM_SW_WAIT: if (i_source_ready[new_oscillator]) begin
                sw_next = OSM_SW_DONE;
            end
            OSM_SW_DONE: begin
                ctrl_next[OSM_POS_CURRENT_OSCILLATOR +: 3] = new_oscillator; // [R18]
                ctrl_next[OSM_POS_SWREQ] = 1'b0; // [R14]
                done_evt = 1'b1;
                sw_next  = OSM_SW_IDLE;
            end
            default: sw_next = OSM_SW_IDLE;
        endcase
        if (fail_evt) begin
            ctrl_next[OSM_POS_FAIL] = 1'b1; // [R15]
            ctrl_next[OSM_POS_CURRENT_OSCILLATOR +: 3] = OSM_SRC_FRC; // [R2]
            ctrl_next[OSM_POS_SWREQ] = 1'b0;
            sw_next = OSM_SW_IDLE;
        end
        ctrl_next = ctrl_next & OSM_CTRL_WMASK | (ctrl_next & 32'h0000_7000);
    end

    // status, mask, bus answer, outputs
    always_comb begin
        stat_next = stat_reg;
        mask_next = mask_reg;
        if (req && i_avs_write && i_avs_address == OSM_OFF_STATUS) begin
            stat_next = stat_reg & ~i_avs_writedata[OSM_NEVT-1:0];
        end
        if (req && i_avs_write && i_avs_address == OSM_OFF_MASK) begin
            mask_next = i_avs_writedata[OSM_NEVT-1:0];
        end
        // set wins over clear
        stat_next[OSM_EVT_FAIL]   = stat_next[OSM_EVT_FAIL] | fail_evt;
        stat_next[OSM_EVT_SWDONE] = stat_next[OSM_EVT_SWDONE] | done_evt;
        ack_next   = req;
        wreq_next  = !req;
        rdata_next = 32'h0000_0000;
        if (req && i_avs_read) begin
            unique case (i_avs_address)
                OSM_OFF_CTRL:   rdata_next = ctrl_reg; // [R7]
                OSM_OFF_UNLOCK: rdata_next = {30'h0, ustate_reg};
                OSM_OFF_STATUS: rdata_next = 32'(stat_reg);
                OSM_OFF_MASK:   rdata_next = 32'(mask_reg);
                default:        rdata_next = 32'h0000_0000;
            endcase
        end
        // next value, so the selected source never shows for a cycle on wake
        src_next = (twospd_next || fail_evt) ? OSM_SRC_FRC
                   : osm_field3(ctrl_next, OSM_POS_CURRENT_OSCILLATOR); // [R2] [R6]
        nmi_next = (nmi_reg || fail_evt) && ctrl_next[OSM_POS_FAIL]; // [R2]
        irq_next = |(stat_next & mask_next);
        clock_output_pin_next = (current_oscillator == OSM_SRC_FRC || current_oscillator == OSM_SRC_PRIMARY_OSCILLATOR)
                    ? d.pb1_half : 1'b0; // [R12]
        flash_next = i_flash_program; // [R13]
    end

    assign d.div_sel = osm_field3(ctrl_reg, OSM_POS_DIV); // [R4]
    assign d.run     = !sleep_reg; // [R3]

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_reg   <= 32'h0000_0000;
            ustate_reg <= 2'd0;
            uwin_reg   <= 4'h0;
            strap_reg  <= 1'b1;
            sw_reg     <= OSM_SW_IDLE;
            wd_reg     <= 16'h0000;
            sleep_reg  <= 1'b0;
            idle_reg   <= 1'b0;
            twospd_reg <= 1'b0;
            stat_reg   <= '0;
            mask_reg   <= '0;
            rdata_reg  <= 32'h0000_0000;
            ack_reg    <= 1'b0;
            wreq_reg   <= 1'b1;
            src_reg    <= OSM_SRC_FRC;
            nmi_reg    <= 1'b0;
            irq_reg    <= 1'b0;
            clock_output_pin_reg   <= 1'b0;
            flash_reg  <= 1'b0;
            frcen_reg  <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            ustate_reg <= ustate_next;
            uwin_reg   <= uwin_next;
            strap_reg  <= strap_next;
            sw_reg     <= sw_next;
            wd_reg     <= wd_next;
            sleep_reg  <= sleep_next;
            idle_reg   <= idle_next;
            twospd_reg <= twospd_next;
            stat_reg   <= stat_next;
            mask_reg   <= mask_next;
            rdata_reg  <= rdata_next;
            ack_reg    <= ack_next;
            wreq_reg   <= wreq_next;
            src_reg    <= src_next;
            nmi_reg    <= nmi_next;
            irq_reg    <= irq_next;
            clock_output_pin_reg   <= clock_output_pin_next;
            flash_reg  <= flash_next;
            frcen_reg  <= d.frc_en;
        end
    end

    assign o_avs_readdata        = rdata_reg;
    assign o_avs_waitrequest     = wreq_reg;
    assign o_system_clock_source = src_reg;
    assign o_failsafe_nmi        = nmi_reg;
    assign o_irq                 = irq_reg;
    assign o_sleeping            = sleep_reg;
    assign o_idle                = idle_reg;
    assign o_dream_mode_enable   = ctrl_reg[OSM_POS_DREAM]; // [R5]
    assign o_internal_fast_rc_en = frcen_reg;
    assign o_clock_output_pin    = clock_output_pin_reg;
    assign o_flash_use_fast_rc   = flash_reg;
endmodule

// ---- sim/osm_top_chk.sv ----
/* Port checker for osm_top: bus answer timing, fail-safe and modes.
   Assumes it is bound to osm_top and FAIL_CYC is handed on. */
`timescale 1ns/1ps
module osm_top_chk
    import osm_pkg::*;
#(
    parameter int FAIL_CYC = OSM_FAIL_CYC
)(
    input wire logic       i_clk_sys,
    input wire logic       i_reset_n,
    input wire logic       i_avs_read,
    input wire logic       i_avs_write,
    input wire logic       o_avs_waitrequest,
    input wire logic       i_system_clock_tick,
    input wire logic       i_wait_instr,
    input wire logic       i_flash_program,
    input wire logic [2:0] o_system_clock_source,
    input wire logic       o_failsafe_nmi,
    input wire logic       o_sleeping,
    input wire logic       o_idle,
    input wire logic       o_clock_output_pin,
    input wire logic       o_flash_use_fast_rc
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    logic [15:0] quiet_reg;
    logic [15:0] quiet_next;
    // counts a silent monitored clock; a few cycles slack for the flag pipe
    always_comb begin
        quiet_next = quiet_reg + 16'h0001;
        if (i_system_clock_tick || o_sleeping || o_failsafe_nmi ||
            o_system_clock_source == OSM_SRC_FRC) begin
            quiet_next = 16'h0000;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) quiet_reg <= 16'h0000;
        else quiet_reg <= quiet_next;
    end
    property p_wait_one; (i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("late answer");
    property p_wait_stand; !o_avs_waitrequest |=> o_avs_waitrequest;
    endproperty
    a_wait_stand: assert property (p_wait_stand) else $error("long answer");
    property p_fail_frc; $rose(o_failsafe_nmi)
        |-> o_system_clock_source == OSM_SRC_FRC; endproperty
    a_fail_frc: assert property (p_fail_frc) else $error("no frc");
    property p_fail_bound; quiet_reg <= FAIL_CYC + 4; endproperty
    a_fail_bound: assert property (p_fail_bound) else $error("no nmi");
    property p_sleep_quiet; o_sleeping && $past(o_sleeping, 2)
        |-> !$rose(o_failsafe_nmi); endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("nmi");
    // pin pipe needs two cycles out of reset before it toggles
    property p_clk_pin; $stable(o_system_clock_source)
        && $past(i_reset_n) && $past(i_reset_n, 2)
        && (o_system_clock_source == OSM_SRC_FRC ||
            o_system_clock_source == OSM_SRC_PRIMARY_OSCILLATOR)
        |-> o_clock_output_pin != $past(o_clock_output_pin); endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("pin idle");
    property p_flash; $past(i_reset_n)
        |-> o_flash_use_fast_rc == $past(i_flash_program);
    endproperty
    a_flash: assert property (p_flash) else $error("flash clock");
    property p_mode_excl; !(o_sleeping && o_idle); endproperty
    a_mode_excl: assert property (p_mode_excl) else $error("modes");
    property p_wait_mode; i_wait_instr |-> ##[1:2] (o_sleeping || o_idle);
    endproperty
    a_wait_mode: assert property (p_wait_mode) else $error("no mode");
    property p_src_legal; o_system_clock_source <= OSM_SRC_LOW_POWER_RC; endproperty
    a_src_legal: assert property (p_src_legal) else $error("src code");
endmodule
bind osm_top osm_top_chk #(.FAIL_CYC(FAIL_CYC)) i_osm_top_chk (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .i_system_clock_tick(i_system_clock_tick), .i_wait_instr(i_wait_instr),
    .i_flash_program(i_flash_program),
    .o_system_clock_source(o_system_clock_source),
    .o_failsafe_nmi(o_failsafe_nmi), .o_sleeping(o_sleeping),
    .o_idle(o_idle), .o_clock_output_pin(o_clock_output_pin),
    .o_flash_use_fast_rc(o_flash_use_fast_rc));

// ---- sim/osm_src_model.sv ----
/* Oscillator source model: activity ticks of the running clock and
   per-source ready flags. Assumes the bench commands stops and start-ups. */
`timescale 1ns/1ps
module osm_src_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic       i_stop,
    input  wire logic [5:0] i_ready,
    output logic            o_tick,
    output logic [5:0]      o_source_ready
);
    logic [5:0] rdy_reg;
    // ready lags the enable by two cycles, like a real start-up
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_tick         <= 1'b0;
            rdy_reg        <= 6'h00;
            o_source_ready <= 6'h00;
        end else begin
            o_tick         <= !i_stop;
            rdy_reg        <= i_ready;
            o_source_ready <= rdy_reg;
        end
    end
endmodule

// ---- sim/osm_top_test.sv ----
/* Self-checking bench for osm_top over its Avalon-MM register port.
   Assumes osm_src_model stands in for the clock sources. */
`timescale 1ns/1ps
module osm_top_test;
    import osm_pkg::*;
    localparam int FC = 16;
    logic        clk, rst_n, rd, wr, fuse, wt, wake, fprog, stop;
    logic        wtrq, nmi, irq, slp, idl, drm, fren, cpin, ffrc, tick;
    logic [3:0]  addr;
    logic [2:0]  nf, src;
    logic [5:0]  rdy, srdy;
    logic [31:0] wdata, rdata, q, cnt;
    int          n_errors, n_tests;
    int          dv[8] = '{1, 2, 4, 8, 16, 32, 64, 256};
    osm_top #(.FAIL_CYC(FC)) i_osm_top (.i_clk_sys(clk), .i_reset_n(rst_n),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wtrq),
        .i_two_speed_startup_fuse(fuse), .i_fuse_new_oscillator(nf),
        .i_system_clock_tick(tick), .i_source_ready(srdy),
        .i_wait_instr(wt), .i_wake(wake), .i_flash_program(fprog),
        .o_system_clock_source(src), .o_failsafe_nmi(nmi), .o_irq(irq),
        .o_sleeping(slp), .o_idle(idl), .o_dream_mode_enable(drm),
        .o_internal_fast_rc_en(fren), .o_clock_output_pin(cpin),
        .o_flash_use_fast_rc(ffrc));
    osm_src_model i_osm_src_model (.i_clk_sys(clk), .i_reset_n(rst_n),
        .i_stop(stop), .i_ready(rdy), .o_tick(tick), .o_source_ready(srdy));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk);
        wr <= w; rd <= !w; addr <= a; wdata <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (wtrq !== 1'b0 && k < 20);
        if (wtrq !== 1'b0) begin
            n_errors++;
            wrap_up();
        end
        q = rdata;
        wr <= 1'b0; rd <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [3:0] a,
                        input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, e, q);
    endtask
    task automatic ulk(input logic [31:0] d);
        bus(1'b1, 4'h4, OSM_KEY_ONE);
        bus(1'b1, 4'h4, OSM_KEY_TWO);
        bus(1'b1, 4'h0, d);
    endtask
    task automatic wsrc(input logic [2:0] s);
        int k;
        k = 0;
        while (src !== s && k < 100) begin
            @(posedge clk);
            k++;
        end
        chk("source", {29'h0, s}, {29'h0, src});
    endtask
    task automatic ichk(input logic e);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic rst(input logic f, input logic [2:0] n);
        rst_n <= 1'b0; fuse <= f; nf <= n;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        {rd, wr, wt, wake, fprog, stop, rst_n} = 7'h00;
        addr = 4'h0; wdata = 32'h0000_0000; rdy = 6'h01;
        fuse = 1'b0; nf = 3'h0;
        n_errors = 0; n_tests = 0;
        rst(1'b0, 3'h0);
        rchk("ctrl reset", 4'h0, 32'h0000_0000);
        bus(1'b1, 4'h0, 32'h0100_0000);
        rchk("ctrl locked", 4'h0, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            fprog <= i[0];
            ulk({5'h00, i[2:0], 24'h00_0000});
            repeat (300) @(posedge clk);
            cnt = 0;
            repeat (512) begin
                @(posedge clk);
                cnt += {31'h0, fren};
            end
            chk("divider", 512 / dv[i], cnt);
        end
        $display("reset, unlock and divider tests done");
        rdy <= 6'h05;
        ulk(32'hFFFF_FA61);
        wsrc(OSM_SRC_PRIMARY_OSCILLATOR);
        rchk("ctrl switched", 4'h0, 32'h07A0_2200);
        chk("dream", 32'h1, {31'h0, drm});
        rchk("status", 4'h8, 32'h0000_0002);
        bus(1'b1, 4'hc, 32'h0000_0001);
        ichk(1'b0);
        bus(1'b1, 4'hc, 32'h0000_0003);
        ichk(1'b1);
        bus(1'b1, 4'h8, 32'h0000_0002);
        ichk(1'b0);
        rchk("unmapped", 4'h6, 32'h0000_0000);
        $display("switch and interrupt tests done");
        stop <= 1'b1;
        for (int k = 0; k < 4 * FC && nmi !== 1'b1; k++) @(posedge clk);
        chk("nmi", 32'h1, {31'h0, nmi});
        wsrc(OSM_SRC_FRC);
        rchk("ctrl fail", 4'h0, 32'h07A0_0208);
        ichk(1'b1);
        stop <= 1'b0;
        ulk(32'h07A0_0200);
        ichk(1'b1);
        chk("nmi clear", 32'h0, {31'h0, nmi});
        bus(1'b1, 4'h8, 32'h0000_0001);
        ichk(1'b0);
        $display("fail-safe test done");
        ulk(32'h07A0_0211);
        wsrc(OSM_SRC_PRIMARY_OSCILLATOR);
        wt <= 1'b1;
        @(posedge clk);
        wt <= 1'b0;
        repeat (2) @(posedge clk);
        chk("sleep", 32'h1, {31'h0, slp});
        stop <= 1'b1; rdy <= 6'h01;
        repeat (4 * FC) @(posedge clk);
        chk("asleep nmi", 32'h0, {31'h0, nmi});
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (3) @(posedge clk);
        chk("two speed", 32'h0, {29'h0, src});
        rdy <= 6'h05; stop <= 1'b0;
        wsrc(OSM_SRC_PRIMARY_OSCILLATOR);
        ulk(32'h07A0_0280);
        ulk(32'h07A0_0101);
        rchk("ctrl lock", 4'h0, 32'h07A0_2280);
        wt <= 1'b1;
        @(posedge clk);
        wt <= 1'b0;
        repeat (2) @(posedge clk);
        chk("idle", 32'h1, {31'h0, idl});
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (2) @(posedge clk);
        chk("idle wake", 32'h0, {31'h0, idl});
        $display("sleep and lock tests done");
        rdy <= 6'h01;
        rst(1'b1, OSM_SRC_PRIMARY_OSCILLATOR);
        rchk("ctrl fuse", 4'h0, 32'h0000_0201);
        rdy <= 6'h05;
        wsrc(OSM_SRC_PRIMARY_OSCILLATOR);
        rchk("ctrl boot", 4'h0, 32'h0000_2200);
        $display("fuse reset test done");
        wrap_up();
    end
endmodule
